// file: verification/bcd_calendar_clock_alarm_values_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
   $display("CHECK FAILED %0t: got %h expected %h", $time, (a), (e)); end end
module bcd_calendar_clock_alarm_values_tb;
   import rtc_calendar_pkg::*;
   logic        ref_clk     = 1'b0;
   logic        rst         = 1'b1;
   cpu_access_t cpu         = '0;
   logic        extClk      = 1'b0;
   logic        rcClk       = 1'b0;
   logic        clkSel      = 1'b0;
   logic        extRun      = 1'b1;
   logic [7:0]  rdData;
   logic        clockPinOut;
   calendar_t   timeNow;
   int          err_count   = 0;
   int          comparisons = 0;
   int          cycles      = 0;

   rtc_calendar #(.PRESCALE(4)) dut_u (
      .ref_clk(ref_clk), .rst(rst), .cpu(cpu), .externalSlowClk(extClk),
      .internalRcClk(rcClk), .counterClockSelect(clkSel), .rdData(rdData),
      .clockPinOut(clockPinOut), .timeNow(timeNow));

   always #5 ref_clk = ~ref_clk;
   // slow sources sped up; external one stands still while off
   always #80 extClk = extRun & ~extClk;
   always #110 rcClk = ~rcClk;

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   // one access per edge; read data valid on return
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
      cpu = '{w, ~w, a, d};
      @(posedge ref_clk);
      #1;
   endtask : acc

   task automatic idle;
      cpu = '0;
      @(posedge ref_clk);
      #1;
   endtask : idle

   task automatic unlock(input logic [7:0] cfg);
      acc(1'b1, ADDR_UNLOCK_SEQUENCE, UNLOCK_KEY_FIRST);
      acc(1'b1, ADDR_UNLOCK_SEQUENCE, UNLOCK_KEY_SECOND);
      acc(1'b1, ADDR_CLOCK_CONFIG, cfg);
   endtask : unlock

   ////////////////////////////////////////////////////////////
   task automatic t_locked;
      acc(1'b1, ADDR_CLOCK_CONFIG, 8'h80);
      acc(1'b1, ADDR_TIMER_WINDOW_LOW, 8'h33);
      acc(1'b0, ADDR_CLOCK_CONFIG, 8'h00);
      `CHK(rdData, 8'h00)
      acc(1'b0, ADDR_TIMER_WINDOW_LOW, 8'h00);
      `CHK(rdData, 8'h00)
      acc(1'b1, ADDR_UNLOCK_SEQUENCE, UNLOCK_KEY_FIRST);
      acc(1'b0, ADDR_CLOCK_CONFIG, 8'h00);
      acc(1'b1, ADDR_UNLOCK_SEQUENCE, UNLOCK_KEY_SECOND);
      acc(1'b1, ADDR_CLOCK_CONFIG, 8'ha0);
      acc(1'b0, ADDR_CLOCK_CONFIG, 8'h00);
      `CHK(rdData, 8'h00)
      unlock(8'h20);
      acc(1'b0, ADDR_CLOCK_CONFIG, 8'h00);
      `CHK(rdData, 8'h20)
      idle();
   endtask : t_locked

   task automatic t_alarm;
      logic [7:0] wv[6] = '{8'hf1, 8'hf2, 8'he3, 8'hfe, 8'hd9, 8'hc5};
      logic [7:0] ev[6] = '{8'h31, 8'h12, 8'h23, 8'h06, 8'h59, 8'h45};
      acc(1'b1, ADDR_ALARM_CONFIG, 8'h02);
      for (int i = 0; i < 6; i++)
         acc(1'b1, i[0] ? ADDR_ALARM_WINDOW_HIGH : ADDR_ALARM_WINDOW_LOW, wv[i]);
      acc(1'b1, ADDR_CLOCK_CONFIG, 8'h00);
      acc(1'b1, ADDR_ALARM_CONFIG, 8'h02);
      acc(1'b1, ADDR_ALARM_WINDOW_LOW, 8'h05);
      for (int i = 0; i < 6; i++)
      begin
         acc(1'b0, i[0] ? ADDR_ALARM_WINDOW_HIGH : ADDR_ALARM_WINDOW_LOW, 8'h00);
         `CHK(rdData, ev[i])
      end
      acc(1'b0, ADDR_ALARM_WINDOW_HIGH, 8'h00);
      `CHK(rdData, 8'h45)
      idle();
   endtask : t_alarm

   task automatic set_time(input calendar_t c);
      unlock(8'h23);
      acc(1'b1, ADDR_TIMER_WINDOW_LOW, c.year);
      acc(1'b1, ADDR_TIMER_WINDOW_HIGH, 8'h00);
      acc(1'b1, ADDR_TIMER_WINDOW_LOW, c.day);
      acc(1'b1, ADDR_TIMER_WINDOW_HIGH, c.month);
      acc(1'b1, ADDR_TIMER_WINDOW_LOW, c.hours);
      acc(1'b1, ADDR_TIMER_WINDOW_HIGH, {5'h0, c.weekday});
      acc(1'b1, ADDR_TIMER_WINDOW_LOW, c.seconds);
      acc(1'b1, ADDR_TIMER_WINDOW_HIGH, c.minutes);
      acc(1'b1, ADDR_CLOCK_CONFIG, 8'ha0);
      idle();
   endtask : set_time

   // last row runs from the internal source with the external one stopped
   task automatic t_carry;
      calendar_t st[7] = '{{8'h99, 8'h12, 8'h31, 3'h6, 24'h235959},
         {8'h23, 8'h02, 8'h28, 3'h2, 24'h235959}, {8'h24, 8'h02, 8'h28, 3'h2, 24'h235959},
         {8'h24, 8'h02, 8'h29, 3'h3, 24'h235959}, {8'h25, 8'h09, 8'h30, 3'h1, 24'h235959},
         {8'h25, 8'h01, 8'h09, 3'h4, 24'h095959}, {8'h25, 8'h01, 8'h19, 3'h5, 24'h235959}};
      calendar_t ex[7] = '{{8'h00, 8'h01, 8'h01, 3'h0, 24'h0},
         {8'h23, 8'h03, 8'h01, 3'h3, 24'h0}, {8'h24, 8'h02, 8'h29, 3'h3, 24'h0},
         {8'h24, 8'h03, 8'h01, 3'h4, 24'h0}, {8'h25, 8'h10, 8'h01, 3'h2, 24'h0},
         {8'h25, 8'h01, 8'h09, 3'h4, 24'h100000}, {8'h25, 8'h01, 8'h20, 3'h6, 24'h0}};
      calendar_t was;
      for (int i = 0; i < 7; i++)
      begin
         clkSel = (i == 6);
         extRun = (i != 6);
         set_time(st[i]);
         was = timeNow;
         for (int n = 0; n < 300 && timeNow === was; n++)
         begin
            @(posedge ref_clk);
            #1;
         end
         `CHK(timeNow, ex[i])
      end
      clkSel = 1'b0;
      extRun = 1'b1;
   endtask : t_carry

   task automatic t_pin;
      int   hi;
      int   rise;
      logic prev;
      for (int s = 0; s < 4; s++)
      begin
         acc(1'b1, ADDR_PAD_CONFIGURATION, {6'h0, s[1:0]});
         idle();
         hi = 0;
         rise = 0;
         prev = 1'b0;
         repeat (300)
         begin
            @(posedge ref_clk);
            #1;
            hi += (clockPinOut === 1'b1);
            rise += (clockPinOut === 1'b1 && prev !== 1'b1);
            prev = clockPinOut;
         end
         if (s == 0 || s == 3)
            `CHK(hi, 0)
         else if (s == 1)
            `CHK(hi == rise && rise >= 4 && rise <= 5, 1'b1)
         else
            `CHK(hi > rise && rise > 9, 1'b1)
      end
   endtask : t_pin

   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      t_locked();
      t_alarm();
      t_carry();
      t_pin();
      report_and_stop();
   end
endmodule : bcd_calendar_clock_alarm_values_tb

// file: verification/rtc_calendar_asserts.sv
`timescale 1ns/100ps
module rtc_calendar_asserts
   import rtc_calendar_pkg::*;
#(
   parameter int PRESCALE = SLOW_CLOCK_HZ
)
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire cpu_access_t cpu,
   input wire logic [7:0]  rdData,
   input wire calendar_t   timeNow
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_sec_top;
      (!cpu.wrEn && timeNow.seconds == SEC_MAX) ##1 (timeNow.seconds != SEC_MAX);
   endsequence
   sequence s_year_top;
      (!cpu.wrEn && timeNow.year == YEAR_MAX) ##1 (timeNow.year != YEAR_MAX);
   endsequence
   sequence s_wday_moved;
      !cpu.wrEn ##1 $changed(timeNow.weekday);
   endsequence
   sequence s_alarm_read;
      cpu.rdEn && (cpu.addr == ADDR_ALARM_WINDOW_LOW || cpu.addr == ADDR_ALARM_WINDOW_HIGH);
   endsequence

   property p_sec_wrap;
      s_sec_top |-> timeNow.seconds == 8'h00 && timeNow.minutes != $past(timeNow.minutes);
   endproperty
   property p_year_wrap;
      s_year_top |-> timeNow.year == 8'h00;
   endproperty
   property p_wday_step;
      s_wday_moved |-> timeNow.weekday ==
         (($past(timeNow.weekday) == WEEKDAY_MAX) ? 3'h0 : $past(timeNow.weekday) + 3'h1);
   endproperty
   property p_alarm_top_bit;
      s_alarm_read |=> rdData[7] == 1'b0;
   endproperty
   property p_sec_range;
      timeNow.seconds[3:0] <= DIGIT_NINE && timeNow.seconds <= SEC_MAX;
   endproperty
   property p_min_range;
      timeNow.minutes[3:0] <= DIGIT_NINE && timeNow.minutes <= SEC_MAX;
   endproperty
   property p_hour_range;
      timeNow.hours[3:0] <= DIGIT_NINE && timeNow.hours <= HOUR_MAX;
   endproperty
   property p_date_range;
      timeNow.month <= MONTH_MAX && timeNow.day <= 8'h31 && timeNow.day[3:0] <= DIGIT_NINE;
   endproperty
   property p_wday_range;
      timeNow.weekday <= WEEKDAY_MAX;
   endproperty

   a_sec_wrap:
      assert property (p_sec_wrap) else $error("seconds did not wrap with minute carry");
   a_year_wrap:
      assert property (p_year_wrap) else $error("year did not wrap to 00");
   a_wday_step:
      assert property (p_wday_step) else $error("weekday stepped wrongly");
   a_alarm_top_bit:
      assert property (p_alarm_top_bit) else $error("alarm read bit 7 not zero");
   a_sec_range:
      assert property (p_sec_range) else $error("seconds not bcd in range");
   a_min_range:
      assert property (p_min_range) else $error("minutes not bcd in range");
   a_hour_range:
      assert property (p_hour_range) else $error("hours not bcd in range");
   a_date_range:
      assert property (p_date_range) else $error("day or month out of range");
   a_wday_range:
      assert property (p_wday_range) else $error("weekday above six");
endmodule : rtc_calendar_asserts

bind rtc_calendar rtc_calendar_asserts #(.PRESCALE(PRESCALE)) chk_u (
   .ref_clk(ref_clk), .rst(rst), .cpu(cpu), .rdData(rdData), .timeNow(timeNow));

// file: verilog/rtc_calendar.sv
`timescale 1ns/100ps

// Function
// RQ1 - alarm month: tens bit4, ones 3-0
// RQ2 - alarm day: tens 5-4, ones 3-0
// RQ3 - alarm weekday in bits 2-0
// RQ4 - alarm hours: tens 5-4, ones 3-0
// RQ5 - alarm minutes: tens 6-4, ones 3-0
// RQ6 - alarm seconds: tens 6-4, ones 3-0
// RQ7 - alarm date/hour writes need unlock bit
// RQ8 - counter on bit changes need unlock
// RQ9 - timer window writes need unlock bit
// RQ10 - all values BCD, digit per nibble
// RQ11 - counter clock: external or internal RC
// RQ12 - software enables secondary oscillator first
// RQ13 - clock pin output chosen by select
// RQ14 - 23:59:59 wraps, carries into day
// RQ15 - 12/31 wraps to 01/01, year increments
// RQ16 - weekday wraps 6 to 0, no carry
// RQ17 - year wraps 99 to 00
// RQ18 - ones digit carries at ten
// RQ19 - weekday Sunday 0 through Saturday 6
// RQ20 - day rolls after month's last day
// RQ21 - leap year when year divisible four
// RQ22 - high alarm access decrements pointer
// RQ23 - unlock only right after 55h AAh
// RQ24 - prescaler divides slow clock to seconds
// RQ25 - weekday advances on day carry
module rtc_calendar
   import rtc_calendar_pkg::*;
#(
   parameter int PRESCALE = SLOW_CLOCK_HZ
)
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire cpu_access_t cpu,
   input  wire logic        externalSlowClk,
   input  wire logic        internalRcClk,
   input  wire logic        counterClockSelect,
   output logic [7:0]       rdData,
   output logic             clockPinOut,
   output calendar_t        timeNow
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] bcdInc(input logic [7:0] v);
      if (v[3:0] == DIGIT_NINE)  // [RQ18]
         bcdInc = {v[7:4] + 4'h1, 4'h0};
      else
         bcdInc = {v[7:4], v[3:0] + 4'h1};
   endfunction : bcdInc

   function automatic logic [7:0] monthLastDay(input logic [7:0] m, input logic [7:0] y);
      logic [4:0] yb;
      yb = 5'(y[7:4]) * 5'd10 + 5'(y[3:0]);
      case (m)
         MONTH_APR, MONTH_JUN, MONTH_SEP, MONTH_NOV: monthLastDay = DAY_LAST_SHORT;  // [RQ20]
         MONTH_FEB: monthLastDay = (yb[1:0] == 2'b00) ? DAY_LAST_LEAP : DAY_LAST_FEB;  // [RQ21]
         default:   monthLastDay = DAY_LAST_LONG;
      endcase
   endfunction : monthLastDay

   ////////////////////////////////////////////////////////////////////////////
   // slow clock select and synchronisation
   logic [2:0] extSync_q;
   logic [2:0] rcSync_q;
   logic       selSync1_q;
   logic       selSync2_q;
   logic       slowLevel;
   logic       slowRise;

   always_ff @(posedge ref_clk)
   begin
      extSync_q  <= {extSync_q[1:0], externalSlowClk};
      rcSync_q   <= {rcSync_q[1:0], internalRcClk};
      selSync1_q <= counterClockSelect;
      selSync2_q <= selSync1_q;
   end

   // edge taken between 2nd and 3rd stage only
   assign slowLevel = selSync2_q ? rcSync_q[1] : extSync_q[1];  // [RQ11]
   assign slowRise  = selSync2_q ? (rcSync_q[1] & ~rcSync_q[2])
                                 : (extSync_q[1] & ~extSync_q[2]);

   ////////////////////////////////////////////////////////////////////////////
   // register state
   typedef enum logic [2:0] {KEY_IDLE = 3'b001, KEY_FIRST = 3'b010, KEY_ARMED = 3'b100} keyStage_t;
   calendar_t  cal_q;
   calendar_t  cal_d;
   alarm_t     alarm_q;
   logic       counterOn_q;
   logic       unlock_q;
   logic [1:0] timerPtr_q;
   logic [1:0] alarmPtr_q;
   logic [1:0] pinSelect_q;
   keyStage_t  keyStage_q;
   logic [31:0] prescale_q;

   wire wrTimerHigh  = cpu.wrEn && cpu.addr == ADDR_TIMER_WINDOW_HIGH;
   wire wrTimerLow   = cpu.wrEn && cpu.addr == ADDR_TIMER_WINDOW_LOW;
   wire wrAlarmHigh  = cpu.wrEn && cpu.addr == ADDR_ALARM_WINDOW_HIGH;
   wire wrAlarmLow   = cpu.wrEn && cpu.addr == ADDR_ALARM_WINDOW_LOW;
   wire wrConfig     = cpu.wrEn && cpu.addr == ADDR_CLOCK_CONFIG;
   wire wrKey        = cpu.wrEn && cpu.addr == ADDR_UNLOCK_SEQUENCE;
   wire wrAlarmCfg   = cpu.wrEn && cpu.addr == ADDR_ALARM_CONFIG;
   wire wrPad        = cpu.wrEn && cpu.addr == ADDR_PAD_CONFIGURATION;
   wire accAlarmHigh = (cpu.wrEn || cpu.rdEn) && cpu.addr == ADDR_ALARM_WINDOW_HIGH;
   wire accTimerHigh = (cpu.wrEn || cpu.rdEn) && cpu.addr == ADDR_TIMER_WINDOW_HIGH;

   wire timerWrOk  = unlock_q;  // [RQ9]
   wire keyArmed   = keyStage_q == KEY_ARMED;
   wire keyPairDone = wrKey && cpu.wrData == UNLOCK_KEY_SECOND;
   wire anyAccess   = cpu.wrEn || cpu.rdEn;
   // a write immediately after the key pair may set the unlock bit
   wire unlockSet  = wrConfig && cpu.wrData[BIT_TIMER_WRITE_UNLOCK] && keyArmed;  // [RQ23]
   wire secSync    = wrTimerLow && timerWrOk && timerPtr_q == PTR_MIN_SEC;
   wire secondTick = counterOn_q && slowRise && prescale_q == 32'(PRESCALE - 1);  // [RQ24]

   ////////////////////////////////////////////////////////////////////////////
   // unlock key sequencer
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         keyStage_q <= KEY_IDLE;
      else if (wrKey && cpu.wrData == UNLOCK_KEY_FIRST)
         keyStage_q <= KEY_FIRST;
      else
         case (keyStage_q)
            KEY_FIRST: keyStage_q <= keyPairDone ? KEY_ARMED : (anyAccess ? KEY_IDLE : KEY_FIRST);
            default:   keyStage_q <= KEY_IDLE;
         endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         unlock_q    <= 1'b0;
         counterOn_q <= 1'b0;
         pinSelect_q <= 2'h0;
      end
      else
      begin
         if (unlockSet)
            unlock_q <= 1'b1;  // [RQ23]
         else if (wrConfig && !cpu.wrData[BIT_TIMER_WRITE_UNLOCK])
            unlock_q <= 1'b0;
         if (wrConfig && (unlock_q || unlockSet))
            counterOn_q <= cpu.wrData[BIT_CLOCK_COUNTER_ON];  // [RQ8]
         if (wrPad)
            pinSelect_q <= cpu.wrData[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // window pointers
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         timerPtr_q <= PTR_MIN_SEC;
         alarmPtr_q <= PTR_MIN_SEC;
      end
      else
      begin
         if (wrConfig)
            timerPtr_q <= cpu.wrData[PTR_LSB +: 2];
         else if (accTimerHigh && timerPtr_q != PTR_MIN_SEC)
            timerPtr_q <= timerPtr_q - 2'h1;
         if (wrAlarmCfg)
            alarmPtr_q <= cpu.wrData[PTR_LSB +: 2];
         else if (accAlarmHigh && alarmPtr_q != PTR_MIN_SEC)
            alarmPtr_q <= alarmPtr_q - 2'h1;  // [RQ22]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // alarm value registers, masked to their fields
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         alarm_q <= '0;
      else
      begin
         if (wrAlarmHigh && alarmPtr_q == PTR_MIN_SEC)
            alarm_q.minutes <= cpu.wrData & MASK_SEC_MIN;  // [RQ5]
         if (wrAlarmLow && alarmPtr_q == PTR_MIN_SEC)
            alarm_q.seconds <= cpu.wrData & MASK_SEC_MIN;  // [RQ6]
         if (unlock_q)  // [RQ7]
         begin
            if (wrAlarmHigh && alarmPtr_q == PTR_WD_HOUR)
               alarm_q.weekday <= cpu.wrData[2:0];  // [RQ3]
            if (wrAlarmLow && alarmPtr_q == PTR_WD_HOUR)
               alarm_q.hours <= cpu.wrData & MASK_HOUR;  // [RQ4]
            if (wrAlarmHigh && alarmPtr_q == PTR_MON_DAY)
               alarm_q.month <= cpu.wrData & MASK_MONTH;  // [RQ1]
            if (wrAlarmLow && alarmPtr_q == PTR_MON_DAY)
               alarm_q.day <= cpu.wrData & MASK_DAY;  // [RQ2]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // calendar counting chain
   wire secWrap  = cal_q.seconds == SEC_MAX;
   wire minWrap  = secWrap && cal_q.minutes == SEC_MAX;
   wire dayCarry = minWrap && cal_q.hours == HOUR_MAX;  // [RQ14]
   wire dayLast  = cal_q.day == monthLastDay(cal_q.month, cal_q.year);
   wire yearCarry = dayCarry && dayLast && cal_q.month == MONTH_MAX;  // [RQ15]

   always_comb
   begin
      cal_d = cal_q;
      if (secondTick)
      begin
         cal_d.seconds = secWrap ? 8'h00 : bcdInc(cal_q.seconds);  // [RQ10]
         if (secWrap)
            cal_d.minutes = (cal_q.minutes == SEC_MAX) ? 8'h00 : bcdInc(cal_q.minutes);
         if (minWrap)
            cal_d.hours = (cal_q.hours == HOUR_MAX) ? 8'h00 : bcdInc(cal_q.hours);
         if (dayCarry)
         begin
            // sunday 0 .. saturday 6, no carry onward
            cal_d.weekday = (cal_q.weekday == WEEKDAY_MAX) ? 3'h0  // [RQ16] [RQ19]
                                                           : cal_q.weekday + 3'h1;  // [RQ25]
            cal_d.day = dayLast ? DAY_FIRST : bcdInc(cal_q.day);  // [RQ20]
            if (dayLast)
               cal_d.month = (cal_q.month == MONTH_MAX) ? 8'h01 : bcdInc(cal_q.month);
         end
         if (yearCarry)
            cal_d.year = (cal_q.year == YEAR_MAX) ? 8'h00 : bcdInc(cal_q.year);  // [RQ17]
      end
      if (wrTimerHigh && timerWrOk)  // [RQ9]
      begin
         case (timerPtr_q)
            PTR_MIN_SEC: cal_d.minutes = cpu.wrData & MASK_SEC_MIN;
            PTR_WD_HOUR: cal_d.weekday = cpu.wrData[2:0];
            PTR_MON_DAY: cal_d.month   = cpu.wrData & MASK_MONTH;
            default:     cal_d.year    = cal_d.year;
         endcase
      end
      if (wrTimerLow && timerWrOk)
      begin
         case (timerPtr_q)
            PTR_MIN_SEC: cal_d.seconds = cpu.wrData & MASK_SEC_MIN;
            PTR_WD_HOUR: cal_d.hours   = cpu.wrData & MASK_HOUR;
            PTR_MON_DAY: cal_d.day     = cpu.wrData & MASK_DAY;
            default:     cal_d.year    = cpu.wrData;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cal_q      <= '0;
         prescale_q <= '0;
      end
      else
      begin
         cal_q <= cal_d;
         if (secSync || !counterOn_q)
            prescale_q <= '0;
         else if (slowRise)
            prescale_q <= (prescale_q == 32'(PRESCALE - 1)) ? '0 : prescale_q + 32'h1;  // [RQ24]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   logic [7:0] rdNext;
   always_comb
   begin
      rdNext = 8'h00;
      case (cpu.addr)
         ADDR_TIMER_WINDOW_HIGH:
            case (timerPtr_q)
               PTR_MIN_SEC: rdNext = cal_q.minutes;
               PTR_WD_HOUR: rdNext = {5'h00, cal_q.weekday};
               PTR_MON_DAY: rdNext = cal_q.month;
               default:     rdNext = 8'h00;
            endcase
         ADDR_TIMER_WINDOW_LOW:
            case (timerPtr_q)
               PTR_MIN_SEC: rdNext = cal_q.seconds;
               PTR_WD_HOUR: rdNext = cal_q.hours;
               PTR_MON_DAY: rdNext = cal_q.day;
               default:     rdNext = cal_q.year;
            endcase
         ADDR_ALARM_WINDOW_HIGH:
            case (alarmPtr_q)
               PTR_MIN_SEC: rdNext = alarm_q.minutes;
               PTR_WD_HOUR: rdNext = {5'h00, alarm_q.weekday};
               PTR_MON_DAY: rdNext = alarm_q.month;
               default:     rdNext = 8'h00;
            endcase
         ADDR_ALARM_WINDOW_LOW:
            case (alarmPtr_q)
               PTR_MIN_SEC: rdNext = alarm_q.seconds;
               PTR_WD_HOUR: rdNext = alarm_q.hours;
               PTR_MON_DAY: rdNext = alarm_q.day;
               default:     rdNext = 8'h00;
            endcase
         ADDR_CLOCK_CONFIG:
            rdNext = {counterOn_q, 1'b0, unlock_q, 3'h0, timerPtr_q};
         ADDR_ALARM_CONFIG:
            rdNext = {6'h00, alarmPtr_q};
         ADDR_PAD_CONFIGURATION:
            rdNext = {6'h00, pinSelect_q};
         default:
            rdNext = 8'h00;
      endcase
   end

   // clock pin: 0 off, 1 seconds pulse, 2 slow clock, 3 off
   wire pinNext = (pinSelect_q == 2'h1) ? secondTick :
                  (pinSelect_q == 2'h2) ? slowLevel : 1'b0;  // [RQ13]

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rdData      <= 8'h00;
         clockPinOut <= 1'b0;
         timeNow     <= '0;
      end
      else
      begin
         if (cpu.rdEn)
            rdData <= rdNext;
         clockPinOut <= pinNext;
         timeNow     <= cal_d;
      end
   end

endmodule : rtc_calendar

// file: verilog/rtc_calendar_pkg.sv
package rtc_calendar_pkg;

   // register addresses (12-bit special function register space)
   localparam logic [11:0] ADDR_ALARM_WINDOW_LOW  = 12'hf8e;
   localparam logic [11:0] ADDR_ALARM_WINDOW_HIGH = 12'hf8f;
   localparam logic [11:0] ADDR_TIMER_WINDOW_LOW  = 12'hf98;
   localparam logic [11:0] ADDR_TIMER_WINDOW_HIGH = 12'hf99;
   localparam logic [11:0] ADDR_CLOCK_CONFIG      = 12'hf9a;
   localparam logic [11:0] ADDR_UNLOCK_SEQUENCE   = 12'hf7e;
   localparam logic [11:0] ADDR_ALARM_CONFIG      = 12'hf91;
   localparam logic [11:0] ADDR_PAD_CONFIGURATION = 12'hf3c;

   // clock config fields
   localparam int BIT_CLOCK_COUNTER_ON   = 7;
   localparam int BIT_TIMER_WRITE_UNLOCK = 5;
   localparam int PTR_LSB                = 0;

   localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h55;
   localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;

   // window pointer codes
   localparam logic [1:0] PTR_MIN_SEC  = 2'h0;
   localparam logic [1:0] PTR_WD_HOUR  = 2'h1;
   localparam logic [1:0] PTR_MON_DAY  = 2'h2;
   localparam logic [1:0] PTR_YEAR     = 2'h3;

   // prescaler: 32768 source edges per second
   localparam int SLOW_CLOCK_HZ = 32768;

   // bcd limits
   localparam logic [3:0] DIGIT_NINE  = 4'h9;
   localparam logic [7:0] SEC_MAX     = 8'h59;
   localparam logic [7:0] HOUR_MAX    = 8'h23;
   localparam logic [7:0] MONTH_MAX   = 8'h12;
   localparam logic [7:0] YEAR_MAX    = 8'h99;
   localparam logic [2:0] WEEKDAY_MAX = 3'h6;
   localparam logic [7:0] DAY_FIRST   = 8'h01;
   localparam logic [7:0] MONTH_FEB   = 8'h02;

   // month ends and the thirty-day months
   localparam logic [7:0] MONTH_APR      = 8'h04;
   localparam logic [7:0] MONTH_JUN      = 8'h06;
   localparam logic [7:0] MONTH_SEP      = 8'h09;
   localparam logic [7:0] MONTH_NOV      = 8'h11;
   localparam logic [7:0] DAY_LAST_LONG  = 8'h31;
   localparam logic [7:0] DAY_LAST_SHORT = 8'h30;
   localparam logic [7:0] DAY_LAST_LEAP  = 8'h29;
   localparam logic [7:0] DAY_LAST_FEB   = 8'h28;

   // field masks (reserved bits read zero)
   localparam logic [7:0] MASK_SEC_MIN = 8'h7f;
   localparam logic [7:0] MASK_HOUR    = 8'h3f;
   localparam logic [7:0] MASK_DAY     = 8'h3f;
   localparam logic [7:0] MASK_WEEKDAY = 8'h07;
   localparam logic [7:0] MASK_MONTH   = 8'h1f;

   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [2:0] weekday;
      logic [7:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
   } calendar_t;

   typedef struct packed {
      logic [7:0] month;
      logic [7:0] day;
      logic [2:0] weekday;
      logic [7:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
   } alarm_t;

   typedef struct packed {
      logic        wrEn;
      logic        rdEn;
      logic [11:0] addr;
      logic [7:0]  wrData;
   } cpu_access_t;

endpackage : rtc_calendar_pkg
